//--- logic/tcu_timer_core.sv
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tcu_timer_core #(
  parameter int unsigned PRESC_W = 10
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        crystal_osc_pin_one_i,
  input  wire logic        compare_irq_ack_i,
  input  wire logic        overflow_irq_ack_i,
  output logic             compare_irq_o,
  output logic             overflow_irq_o,
  output logic             compare_output_pin_o,
  output logic             compare_output_pin_oe_o
);

  tcu_pkg::tcu_wave_e wave_q;
  tcu_pkg::tcu_wave_e wave_n;
  logic [1:0]  com_q;
  logic [1:0]  com_n;
  logic [2:0]  cs_q;
  logic        async_q;
  logic [7:0]  count_q;
  logic [7:0]  cmp_q;
  logic [7:0]  cmp_buf_q;
  logic        ovf_en_q;
  logic        cmp_en_q;
  logic        ovf_flag_q;
  logic        cmp_flag_q;
  logic        port_q;
  logic        dir_q;
  logic        oc_q;
  logic        up_q;
  logic        block_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        pin_q;
  logic        pin_oe_q;
  logic        cmp_irq_q;
  logic        ovf_irq_q;
  logic        tick;
  logic        wr;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_cmp;
  logic        wr_irqen;
  logic        wr_flags;
  logic        wr_port;
  logic        pwm;
  logic        pwm_n;
  logic        eq;
  logic        at_max;
  logic        at_bot;
  logic        match;
  logic        force_cmp;
  logic        fast_bot;
  logic        ovf_set;
  logic [31:0] rdata_d;
  logic [7:0]  wd;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: every access waits one cycle, then completes with waitrequest low.

  assign wd       = avs_writedata_i[7:0];
  assign wr       = avs_write_i && !wait_q;
  assign wr_ctrl  = wr && avs_address_i == tcu_pkg::TCU_OFS_CTRL && avs_byteenable_i[0];
  assign wr_count = wr && avs_address_i == tcu_pkg::TCU_OFS_COUNT && avs_byteenable_i[0];
  assign wr_cmp   = wr && avs_address_i == tcu_pkg::TCU_OFS_CMP && avs_byteenable_i[0];
  assign wr_irqen = wr && avs_address_i == tcu_pkg::TCU_OFS_IRQEN && avs_byteenable_i[0];
  assign wr_flags = wr && avs_address_i == tcu_pkg::TCU_OFS_FLAGS && avs_byteenable_i[0];
  assign wr_port  = wr && avs_address_i == tcu_pkg::TCU_OFS_PORT && avs_byteenable_i[0];

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read_i || avs_write_i) && wait_q);
    end
  end

  always_comb begin
    rdata_d = '0;
    unique case (avs_address_i)
      tcu_pkg::TCU_OFS_CTRL: begin
        rdata_d[tcu_pkg::TCU_WAVE_LSB +: 2] = wave_q;
        rdata_d[tcu_pkg::TCU_COM_LSB +: 2]  = com_q;
        rdata_d[tcu_pkg::TCU_CS_LSB +: 3]   = cs_q;
        rdata_d[tcu_pkg::TCU_ASYNC_BIT]     = async_q;
      end
      tcu_pkg::TCU_OFS_COUNT: rdata_d[7:0] = count_q;
      tcu_pkg::TCU_OFS_CMP:   rdata_d[7:0] = pwm ? cmp_buf_q : cmp_q;
      tcu_pkg::TCU_OFS_IRQEN: begin
        rdata_d[tcu_pkg::TCU_OVF_BIT] = ovf_en_q;
        rdata_d[tcu_pkg::TCU_CMP_BIT] = cmp_en_q;
      end
      tcu_pkg::TCU_OFS_FLAGS: begin
        rdata_d[tcu_pkg::TCU_OVF_BIT] = ovf_flag_q;
        rdata_d[tcu_pkg::TCU_CMP_BIT] = cmp_flag_q;
      end
      tcu_pkg::TCU_OFS_PORT: begin
        rdata_d[tcu_pkg::TCU_PDATA_BIT] = port_q;
        rdata_d[tcu_pkg::TCU_PDIR_BIT]  = dir_q;
      end
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= '0;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control and configuration registers.

  assign wave_n = wr_ctrl ? tcu_pkg::tcu_wave_e'(wd[tcu_pkg::TCU_WAVE_LSB +: 2]) : wave_q;
  assign com_n  = wr_ctrl ? wd[tcu_pkg::TCU_COM_LSB +: 2] : com_q;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wave_q <= tcu_pkg::TCU_WAVE_NORMAL;
      com_q  <= tcu_pkg::TCU_COM_NONE;
      cs_q   <= tcu_pkg::TCU_CS_STOP;
    end else if (wr_ctrl) begin
      wave_q <= wave_n;
      com_q  <= com_n;
      cs_q   <= wd[tcu_pkg::TCU_CS_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      async_q <= 1'b0;
    end else if (wr && avs_address_i == tcu_pkg::TCU_OFS_CTRL && avs_byteenable_i[1]) begin
      async_q <= avs_writedata_i[tcu_pkg::TCU_ASYNC_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ovf_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
      port_q   <= 1'b0;
      dir_q    <= 1'b0;
    end else begin
      if (wr_irqen) begin
        ovf_en_q <= wd[tcu_pkg::TCU_OVF_BIT];
        cmp_en_q <= wd[tcu_pkg::TCU_CMP_BIT];
      end
      if (wr_port) begin
        port_q <= wd[tcu_pkg::TCU_PDATA_BIT];
        dir_q  <= wd[tcu_pkg::TCU_PDIR_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter unit.

  tcu_tick_gen #(
    .PRESC_W (PRESC_W)
  ) u_tick (
    .clk_sys_i             (clk_sys_i),
    .reset_n_i             (reset_n_i),
    .clock_select_field_i  (cs_q),
    .async_clock_select_i  (async_q),
    .crystal_osc_pin_one_i (crystal_osc_pin_one_i),
    .tick_o                (tick)
  );

  assign pwm    = wave_q == tcu_pkg::TCU_WAVE_PHASE || wave_q == tcu_pkg::TCU_WAVE_FAST;
  assign pwm_n  = wave_n == tcu_pkg::TCU_WAVE_PHASE || wave_n == tcu_pkg::TCU_WAVE_FAST;
  assign at_max = count_q == tcu_pkg::TCU_MAX;
  assign at_bot = count_q == tcu_pkg::TCU_BOTTOM;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q <= tcu_pkg::TCU_BOTTOM;
    end else if (wr_count) begin
      count_q <= wd;
    end else if (tick) begin
      unique case (wave_q)
        tcu_pkg::TCU_WAVE_NORMAL: count_q <= count_q + tcu_pkg::TCU_ONE;
        tcu_pkg::TCU_WAVE_FAST:   count_q <= count_q + tcu_pkg::TCU_ONE;
        tcu_pkg::TCU_WAVE_CTC:    count_q <= eq ? tcu_pkg::TCU_BOTTOM : count_q + tcu_pkg::TCU_ONE;
        tcu_pkg::TCU_WAVE_PHASE: begin
          if (up_q) begin
            count_q <= at_max ? count_q - tcu_pkg::TCU_ONE : count_q + tcu_pkg::TCU_ONE;
          end else begin
            count_q <= at_bot ? count_q + tcu_pkg::TCU_ONE : count_q - tcu_pkg::TCU_ONE;
          end
        end
      endcase
    end
  end

  // Direction only turns in phase correct mode; all other sequences count up.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      up_q <= 1'b1;
    end else if (wave_q != tcu_pkg::TCU_WAVE_PHASE) begin
      up_q <= 1'b1;
    end else if (tick && at_max) begin
      up_q <= 1'b0;
    end else if (tick && at_bot) begin
      up_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output compare unit.

  assign eq        = count_q == cmp_q;
  assign match     = tick && eq && !block_q;
  assign force_cmp = wr_ctrl && wd[tcu_pkg::TCU_FORCE_BIT] && !pwm_n;
  assign fast_bot  = tick && at_max && wave_q == tcu_pkg::TCU_WAVE_FAST;
  assign ovf_set   = tick && (wave_q == tcu_pkg::TCU_WAVE_PHASE ? (at_bot && !up_q) : at_max);

  // A write arms the block even while stopped; it lasts until the next tick has passed.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_q <= tcu_pkg::TCU_BOTTOM;
    end else if (wr_cmp && !pwm) begin
      cmp_q <= wd;
    end else if (pwm && tick && at_max) begin
      cmp_q <= cmp_buf_q;
    end
  end

  // The buffer follows every write so a later switch into a PWM mode starts from it.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_buf_q <= tcu_pkg::TCU_BOTTOM;
    end else if (wr_cmp) begin
      cmp_buf_q <= wd;
    end
  end

  function automatic logic oc_act(input logic [1:0] com, input logic oc);
    unique case (com)
      tcu_pkg::TCU_COM_NONE:   oc_act = oc;
      tcu_pkg::TCU_COM_TOGGLE: oc_act = ~oc;
      tcu_pkg::TCU_COM_CLEAR:  oc_act = 1'b0;
      tcu_pkg::TCU_COM_SET:    oc_act = 1'b1;
    endcase
  endfunction

  // Bottom wins over match in fast mode so a compare value at max gives a steady level.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oc_q <= 1'b0;
    end else if (force_cmp) begin
      oc_q <= oc_act(com_n, oc_q);
    end else if (fast_bot) begin
      if (com_q == tcu_pkg::TCU_COM_CLEAR || com_q == tcu_pkg::TCU_COM_SET) begin
        oc_q <= com_q == tcu_pkg::TCU_COM_CLEAR;
      end
    end else if (match) begin
      unique case (wave_q)
        tcu_pkg::TCU_WAVE_NORMAL: oc_q <= oc_act(com_q, oc_q);
        tcu_pkg::TCU_WAVE_CTC:    oc_q <= oc_act(com_q, oc_q);
        tcu_pkg::TCU_WAVE_FAST:   oc_q <= oc_act(com_q, oc_q);
        tcu_pkg::TCU_WAVE_PHASE: begin
          if (com_q == tcu_pkg::TCU_COM_CLEAR || com_q == tcu_pkg::TCU_COM_SET) begin
            oc_q <= (com_q == tcu_pkg::TCU_COM_SET) == up_q;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags and requests: a set in the same cycle as a clear wins.

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
    end else begin
      cmp_flag_q <= match || (cmp_flag_q && !compare_irq_ack_i
                    && !(wr_flags && wd[tcu_pkg::TCU_CMP_BIT]));
      ovf_flag_q <= ovf_set || (ovf_flag_q && !overflow_irq_ack_i
                    && !(wr_flags && wd[tcu_pkg::TCU_OVF_BIT]));
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_irq_q <= 1'b0;
      ovf_irq_q <= 1'b0;
      pin_q     <= 1'b0;
      pin_oe_q  <= 1'b0;
    end else begin
      cmp_irq_q <= cmp_flag_q && cmp_en_q;
      ovf_irq_q <= ovf_flag_q && ovf_en_q;
      pin_q     <= (com_q != tcu_pkg::TCU_COM_NONE) ? oc_q : port_q;
      pin_oe_q  <= dir_q;
    end
  end

  assign avs_readdata_o          = rdata_q;
  assign avs_waitrequest_o       = wait_q;
  assign compare_irq_o           = cmp_irq_q;
  assign overflow_irq_o          = ovf_irq_q;
  assign compare_output_pin_o    = pin_q;
  assign compare_output_pin_oe_o = pin_oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  AST_STOPPED_HOLDS: assert property (cs_q == tcu_pkg::TCU_CS_STOP && !wr_count |=>
    $stable(count_q)) else $error("Counter moved while stopped.");
  AST_WRITE_PRIO: assert property (wr_count |=> count_q == $past(wd))
    else $error("Counter write lost to counting.");
  AST_MATCH_FLAG: assert property (tick && eq && !block_q |=> cmp_flag_q)
    else $error("Match did not set compare flag.");
  AST_BLOCKED: assert property (block_q && tick && !cmp_flag_q |=> !cmp_flag_q)
    else $error("Blocked match set compare flag.");
  AST_W1C: assert property (wr_flags && wd[tcu_pkg::TCU_CMP_BIT] && !match |=>
    !cmp_flag_q) else $error("Write one did not clear compare flag.");
  AST_DBUF_HOLD: assert property (pwm && !(tick && at_max) |=> $stable(cmp_q))
    else $error("Buffered compare changed away from top.");
  AST_DIRECT_CMP: assert property (wr_cmp && !pwm |=> cmp_q == $past(wd))
    else $error("Direct compare write not applied.");
  AST_FORCE_NOFLAG: assert property (force_cmp && !match && !cmp_flag_q |=>
    !cmp_flag_q) else $error("Force set the compare flag.");
  AST_COM_NONE: assert property (com_q == tcu_pkg::TCU_COM_NONE && !wr_ctrl |=>
    $stable(oc_q)) else $error("Output state moved with mode none.");
  AST_PIN_OVERRIDE: assert property (com_q != tcu_pkg::TCU_COM_NONE |=>
    compare_output_pin_o == $past(oc_q)) else $error("Pin not driven from output state.");
  AST_OVF_NORMAL: assert property (tick && at_max && wave_q == tcu_pkg::TCU_WAVE_NORMAL
    |=> ovf_flag_q) else $error("Overflow flag missed at wrap.");
  AST_CMP_IRQ: assert property (cmp_flag_q && cmp_en_q |=> compare_irq_o)
    else $error("Compare request not raised.");

  COV_MATCH: cover property (match ##1 cmp_flag_q);
  COV_FORCE: cover property (force_cmp);
  COV_RELOAD: cover property (pwm && tick && at_max && cmp_q != cmp_buf_q);
  COV_PHASE_TURN: cover property (wave_q == tcu_pkg::TCU_WAVE_PHASE && ovf_set);

endmodule
`default_nettype wire

//--- logic/tcu_pkg.sv
`default_nettype none
package tcu_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] TCU_OFS_CTRL   = 5'h00;
  localparam logic [4:0] TCU_OFS_COUNT  = 5'h04;
  localparam logic [4:0] TCU_OFS_CMP    = 5'h08;
  localparam logic [4:0] TCU_OFS_IRQEN  = 5'h0c;
  localparam logic [4:0] TCU_OFS_FLAGS  = 5'h10;
  localparam logic [4:0] TCU_OFS_PORT   = 5'h14;

  // Control register fields.
  localparam int unsigned TCU_WAVE_LSB  = 0;
  localparam int unsigned TCU_COM_LSB   = 2;
  localparam int unsigned TCU_CS_LSB    = 4;
  localparam int unsigned TCU_FORCE_BIT = 7;
  localparam int unsigned TCU_ASYNC_BIT = 8;

  // Flag, enable and port register fields.
  localparam int unsigned TCU_OVF_BIT   = 0;
  localparam int unsigned TCU_CMP_BIT   = 1;
  localparam int unsigned TCU_PDATA_BIT = 0;
  localparam int unsigned TCU_PDIR_BIT  = 1;

  // Counter extremes and the count step.
  localparam logic [7:0] TCU_MAX    = 8'hff;
  localparam logic [7:0] TCU_BOTTOM = 8'h00;
  localparam logic [7:0] TCU_ONE    = 8'h01;

  // Compare output mode codes.
  localparam logic [1:0] TCU_COM_NONE   = 2'h0;
  localparam logic [1:0] TCU_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TCU_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TCU_COM_SET    = 2'h3;

  // Clock select code that stops the counter.
  localparam logic [2:0] TCU_CS_STOP = 3'h0;

  // Prescaler masks per clock select code: a tick fires when all masked bits are one.
  localparam logic [9:0] TCU_PRESC_MASK [0:7] = '{10'h000, 10'h000, 10'h007, 10'h01f,
                                                 10'h03f, 10'h07f, 10'h0ff, 10'h3ff};

  typedef enum logic [1:0] {
    TCU_WAVE_NORMAL = 2'b00,
    TCU_WAVE_PHASE  = 2'b01,
    TCU_WAVE_CTC    = 2'b10,
    TCU_WAVE_FAST   = 2'b11
  } tcu_wave_e;

endpackage
`default_nettype wire

//--- logic/tcu_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module tcu_tick_gen #(
  parameter int unsigned PRESC_W = 10
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] clock_select_field_i,
  input  wire logic       async_clock_select_i,
  input  wire logic       crystal_osc_pin_one_i,
  output logic            tick_o
);

  logic               osc_q;
  logic [PRESC_W-1:0] presc_q;
  logic               src_edge;
  logic [PRESC_W-1:0] mask;

  ////////////////////////////////////////////////////////////////////////////////
  // The oscillator pin is counted on its rising edge, so a slow crystal shares the system clock.
  assign src_edge = async_clock_select_i ? (crystal_osc_pin_one_i & ~osc_q) : 1'b1;
  assign mask     = PRESC_W'(tcu_pkg::TCU_PRESC_MASK[clock_select_field_i]);
  assign tick_o   = (clock_select_field_i != tcu_pkg::TCU_CS_STOP) && src_edge
                    && ((presc_q & mask) == mask);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= crystal_osc_pin_one_i;
    end
  end

  // The prescaler restarts while stopped so the first tick after a start has full length.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc_q <= '0;
    end else if (clock_select_field_i == tcu_pkg::TCU_CS_STOP) begin
      presc_q <= '0;
    end else if (src_edge) begin
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  AST_NO_TICK_STOPPED: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    clock_select_field_i == tcu_pkg::TCU_CS_STOP |-> !tick_o)
    else $error("Tick while clock select is stopped.");

endmodule
`default_nettype wire

//--- bench/tcu_timer_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tcu_timer_core_tb;
  localparam logic [4:0] A_CTRL = tcu_pkg::TCU_OFS_CTRL;
  localparam logic [4:0] A_CNT  = tcu_pkg::TCU_OFS_COUNT;
  localparam logic [4:0] A_CMP  = tcu_pkg::TCU_OFS_CMP;
  localparam logic [4:0] A_IEN  = tcu_pkg::TCU_OFS_IRQEN;
  localparam logic [4:0] A_FLG  = tcu_pkg::TCU_OFS_FLAGS;
  localparam logic [4:0] A_PORT = tcu_pkg::TCU_OFS_PORT;
  // Each entry is {expected pin, control byte}, run in order on a stopped counter.
  localparam logic [8:0] OUT_SEQ [0:8] = '{9'h18c, 9'h088, 9'h184, 9'h084, 9'h184,
                                           9'h080, 9'h104, 9'h107, 9'h18b};

  logic        clk_sys_i             = 1'b0;
  logic        reset_n_i             = 1'b0;
  logic [4:0]  avs_address_i         = 5'h00;
  logic        avs_read_i            = 1'b0;
  logic        avs_write_i           = 1'b0;
  logic [31:0] avs_writedata_i       = 32'h0;
  logic [3:0]  avs_byteenable_i      = 4'hf;
  logic        crystal_osc_pin_one_i = 1'b0;
  logic        compare_irq_ack_i     = 1'b0;
  logic        overflow_irq_ack_i    = 1'b0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        compare_irq_o;
  logic        overflow_irq_o;
  logic        compare_output_pin_o;
  logic        compare_output_pin_oe_o;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          cycles      = 0;
  logic [31:0] rdat;

  always #50 clk_sys_i = ~clk_sys_i;

  tcu_timer_core #(.PRESC_W(10)) tcu_timer_core_i (
    .clk_sys_i              (clk_sys_i),
    .reset_n_i              (reset_n_i),
    .avs_address_i          (avs_address_i),
    .avs_read_i             (avs_read_i),
    .avs_write_i            (avs_write_i),
    .avs_writedata_i        (avs_writedata_i),
    .avs_byteenable_i       (avs_byteenable_i),
    .avs_readdata_o         (avs_readdata_o),
    .avs_waitrequest_o      (avs_waitrequest_o),
    .crystal_osc_pin_one_i  (crystal_osc_pin_one_i),
    .compare_irq_ack_i      (compare_irq_ack_i),
    .overflow_irq_ack_i     (overflow_irq_ack_i),
    .compare_irq_o          (compare_irq_o),
    .overflow_irq_o         (overflow_irq_o),
    .compare_output_pin_o   (compare_output_pin_o),
    .compare_output_pin_oe_o(compare_output_pin_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Free-running counts are checked against a window, because the exact tick count
  // across the start and stop writes depends on the cycles the bus handshake takes.
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // The master counts no wait cycles; only the bench's cycle ceiling ends a stuck wait.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_sys_i);
    end
    rdat = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic run(input logic [31:0] on, input logic [31:0] off, input int n);
    wr(A_CTRL, on);
    repeat (n) @(posedge clk_sys_i);
    wr(A_CTRL, off);
  endtask

  task automatic ack(input logic cmp);
    compare_irq_ack_i <= cmp;
    overflow_irq_ack_i <= !cmp;
    @(posedge clk_sys_i);
    compare_irq_ack_i <= 1'b0;
    overflow_irq_ack_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic results;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    foreach (OUT_SEQ[i]) rd(5'(i * 4), 32'h0);
    rd(5'h18, 32'h0);
    wr(A_CNT, 32'h10);
    repeat (10) @(posedge clk_sys_i);
    rd(A_CNT, 32'h10);
    wr(A_IEN, 32'h3);
    wr(A_CMP, 32'h18);
    rd(A_CMP, 32'h18);
    run(32'h10, 32'h00, 20);
    bus(1'b0, A_CNT, 32'h0);
    chk_rng(rdat, 32'h20, 32'h2c);
    rd(A_FLG, 32'h2);
    chk({31'h0, compare_irq_o}, 32'h1);
    wr(A_FLG, 32'h0);
    rd(A_FLG, 32'h2);
    wr(A_FLG, 32'h2);
    rd(A_FLG, 32'h0);
    chk({31'h0, compare_irq_o}, 32'h0);
    // Starting one below the compare value keeps the match from being hidden by the write.
    wr(A_CNT, 32'h17);
    run(32'h10, 32'h00, 5);
    rd(A_FLG, 32'h2);
    ack(1'b1);
    rd(A_FLG, 32'h0);
    wr(A_CNT, 32'hf8);
    run(32'h10, 32'h00, 20);
    rd(A_FLG, 32'h1);
    chk({31'h0, overflow_irq_o}, 32'h1);
    ack(1'b0);
    rd(A_FLG, 32'h0);
    // Writing the compare value into the counter must hide the very next match.
    wr(A_CNT, 32'h18);
    run(32'h10, 32'h00, 5);
    rd(A_FLG, 32'h0);
    wr(A_CTRL, 32'h10);
    wr(A_CNT, 32'h80);
    wr(A_CTRL, 32'h00);
    bus(1'b0, A_CNT, 32'h0);
    chk_rng(rdat, 32'h80, 32'h85);
    wr(A_FLG, 32'h3);
    wr(A_CMP, 32'h05);
    wr(A_CNT, 32'h00);
    run(32'h12, 32'h02, 40);
    bus(1'b0, A_CNT, 32'h0);
    chk_rng(rdat, 32'h00, 32'h05);
    rd(A_FLG, 32'h2);
    wr(A_FLG, 32'h3);
    wr(A_CNT, 32'hf8);
    run(32'h11, 32'h01, 20);
    bus(1'b0, A_CNT, 32'h0);
    chk_rng(rdat, 32'hec, 32'hfa);
    rd(A_FLG, 32'h0);
    wr(A_CTRL, 32'h00);
    wr(A_CMP, 32'h50);
    wr(A_CTRL, 32'h03);
    wr(A_CMP, 32'h20);
    rd(A_CMP, 32'h20);
    wr(A_CNT, 32'h10);
    run(32'h13, 32'h03, 30);
    rd(A_FLG, 32'h0);
    wr(A_CNT, 32'hf0);
    run(32'h13, 32'h03, 60);
    rd(A_FLG, 32'h3);
    wr(A_FLG, 32'h3);
    wr(A_CTRL, 32'h00);
    for (int i = 0; i < 9; i++) begin
      wr(A_CTRL, {24'h0, OUT_SEQ[i][7:0]});
      repeat (3) @(posedge clk_sys_i);
      chk({31'h0, compare_output_pin_o}, {31'h0, OUT_SEQ[i][8]});
    end
    // The output state is set up by force strobes before the pin is turned to output.
    wr(A_PORT, 32'h2);
    rd(A_FLG, 32'h0);
    chk({31'h0, compare_output_pin_oe_o}, 32'h1);
    wr(A_CTRL, 32'h00);
    wr(A_PORT, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    chk({30'h0, compare_output_pin_oe_o, compare_output_pin_o}, 32'h1);
    // Divide by eight: eighty ticking cycles of the system clock give exactly ten counts.
    wr(A_CNT, 32'h00);
    run(32'h20, 32'h00, 77);
    rd(A_CNT, 32'h0a);
    // The oscillator is held still first, so any movement would come from the system clock.
    wr(A_CNT, 32'h00);
    wr(A_CTRL, 32'h110);
    repeat (20) @(posedge clk_sys_i);
    rd(A_CNT, 32'h0);
    repeat (5) begin
      crystal_osc_pin_one_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      crystal_osc_pin_one_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
    end
    rd(A_CNT, 32'h5);
    wr(A_CTRL, 32'h00);
    results();
  end
endmodule
`default_nettype wire
